// ===== design/ptpp_if.sv
// Link wires between the packet source and the packet sink
`timescale 1ns/1ps
`default_nettype none

interface ptpp_if;
  logic       lclk;               // Byte clock, made by the source
  logic [7:0] data;               // Bit 7 is the packet byte's MSB
  logic       packet_start_flag;  // High with the sync byte
  logic       byte_valid_flag;    // Low during filler bytes

  // Source drives everything
  modport src
  (
    output lclk,
    output data,
    output packet_start_flag,
    output byte_valid_flag
  );

  // Sink only listens
  modport snk
  (
    input lclk,
    input data,
    input packet_start_flag,
    input byte_valid_flag
  );
endinterface

`default_nettype wire

// ===== design/ptpp_pkg.sv
// Shared constants and types for the parallel transport packet port
package ptpp_pkg;

  // System clock and ceiling of the byte clock, both in kHz
  localparam int unsigned CLK_KHZ      = 100000;
  localparam int unsigned LINK_MAX_KHZ = 13500;
  // Least half period of the byte clock in system cycles, rounded up
  localparam int unsigned HALF_MIN_CYC =
    (CLK_KHZ + 2 * LINK_MAX_KHZ - 1) / (2 * LINK_MAX_KHZ);

  // Packet geometry
  localparam logic [7:0] LEN_188    = 8'hBC;  // 188 bytes
  localparam logic [7:0] LEN_204    = 8'hCC;  // 204 bytes
  localparam logic [7:0] LAST_188   = 8'hBB;  // Index 187
  localparam logic [7:0] LAST_204   = 8'hCB;  // Index 203
  localparam logic [7:0] IDX_RESET  = 8'h00;
  localparam logic [7:0] CNT_RESET  = 8'h00;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;  // Content of filler bytes
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Packet formats
  typedef enum logic [2:0]
  {
    FMT_188       = 3'b001,
    FMT_204_DUMMY = 3'b010,
    FMT_204_RS    = 3'b100
  } ptpp_fmt_t;

  // Source clock generator states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_HIGH = 3'b100
  } ptpp_state_t;

endpackage

// ===== design/ptpp_snk.sv
// Packet sink: samples the link on its own clock and hands bytes over
`timescale 1ns/1ps
`default_nettype none

module ptpp_snk (
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  ptpp_if.snk                link_if,
  output logic [7:0]         snk_data_out,
  output logic               snk_strobe_out,
  output logic               snk_start_out,
  output logic               snk_byte_valid_out,
  output logic               snk_rs_check_out,
  output ptpp_pkg::ptpp_fmt_t snk_format_out,
  output logic               snk_len_err_out
);
  import ptpp_pkg::*;

  logic [7:0] cap_data_r;
  logic       cap_start_r;
  logic       cap_bval_r;
  logic       cap_tgl_r;
  logic       tgl_s;
  logic       tgl_d_r;
  logic       ev;
  logic [7:0] pos_r;
  logic       in_pkt_r;
  logic       dummy_seen_r;
  logic       len_ok;

  // Capture on the rising byte-clock edge; clock may stop between bytes
  always_ff @(posedge link_if.lclk or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cap_data_r  <= DATA_RESET;
      cap_start_r <= 1'b0;
      cap_bval_r  <= 1'b0;
      cap_tgl_r   <= 1'b0;
    end
    else
    begin
      cap_data_r  <= link_if.data;               // RQ6
      cap_start_r <= link_if.packet_start_flag;  // RQ14
      cap_bval_r  <= link_if.byte_valid_flag;
      cap_tgl_r   <= ~cap_tgl_r;
    end
  end

  // Toggle crossing; captured word stays put for a whole byte period
  ptpp_sync2 #(.WIDTH(1)) u_sync
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (cap_tgl_r),
    .sync_out   (tgl_s)
  );

  assign ev = tgl_s ^ tgl_d_r;

  // A finished packet is 188 all valid, or 204 of either kind
  assign len_ok = ((pos_r == LEN_188) && !dummy_seen_r) || (pos_r == LEN_204);  // RQ1

  // Byte handover to the user side
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      tgl_d_r            <= 1'b0;
      snk_data_out       <= DATA_RESET;
      snk_strobe_out     <= 1'b0;
      snk_start_out      <= 1'b0;
      snk_byte_valid_out <= 1'b0;
      snk_rs_check_out   <= 1'b0;
    end
    else
    begin
      tgl_d_r        <= tgl_s;
      snk_strobe_out <= ev;
      if (ev)
      begin
        snk_data_out       <= cap_data_r;
        snk_start_out      <= cap_start_r;
        snk_byte_valid_out <= cap_bval_r;
        // Filler bytes are never fed to the parity checker
        snk_rs_check_out   <= cap_bval_r && !cap_start_r && in_pkt_r
                              && (pos_r >= LEN_188);  // RQ9
      end
    end
  end

  // Packet tracking, length check and format detection
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pos_r           <= CNT_RESET;
      in_pkt_r        <= 1'b0;
      dummy_seen_r    <= 1'b0;
      snk_format_out  <= FMT_188;
      snk_len_err_out <= 1'b0;
    end
    else
    begin
      snk_len_err_out <= 1'b0;
      if (ev && cap_start_r)
      begin
        if (in_pkt_r)
        begin
          snk_len_err_out <= !len_ok;  // RQ1
          if (pos_r == LEN_188)
            snk_format_out <= FMT_188;  // RQ2
          else if (pos_r == LEN_204)
            snk_format_out <= dummy_seen_r ? FMT_204_DUMMY : FMT_204_RS;  // RQ2
        end
        pos_r        <= 8'h01;
        in_pkt_r     <= 1'b1;
        dummy_seen_r <= !cap_bval_r;
      end
      else if (ev && in_pkt_r)
      begin
        // A byte beyond 204 ends the packet as broken
        if (pos_r == LEN_204)
        begin
          snk_len_err_out <= 1'b1;  // RQ1
          in_pkt_r        <= 1'b0;
        end
        pos_r        <= pos_r + 8'h01;
        dummy_seen_r <= dummy_seen_r | !cap_bval_r;
      end
    end
  end
endmodule

`default_nettype wire

// ===== design/ptpp_src.sv
// Packet source: frames user bytes and drives byte clock and link lines
//
// How it works
// (RQ1) Packets are exactly 188 or 204 bytes
// (RQ2) Plain, dummy-filled and parity-coded formats all supported
// (RQ3) The whole port behaviour is implemented
// (RQ4) One byte per clock with both flags
// (RQ5) Lines change with the clock, plain levels
// (RQ6) Data bit 7 carries the byte's MSB
// (RQ7) Byte-valid flag high for real packet bytes
// (RQ8) Byte-valid flag always high in 188 mode
// (RQ9) Byte-valid flag low on the 16 dummy bytes
// (RQ10) Packet-start flag high with the sync byte
// (RQ11) Link clock ticks only when bytes flow
// (RQ12) Parity bytes come in ready-made from user
// (RQ13) Packet-start flag high one clock per packet
// (RQ14) Byte transferred on the rising clock edge
// (RQ15) Clock rate equals the byte rate
// (RQ16) Clock never above the frequency ceiling
`timescale 1ns/1ps
`default_nettype none

module ptpp_src #(
  parameter int unsigned HALF_CYC = ptpp_pkg::HALF_MIN_CYC
) (
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic [7:0]         src_data_in,
  input  wire logic               src_valid_in,
  output logic                    src_ready_out,
  input  wire ptpp_pkg::ptpp_fmt_t src_format_in,
  output logic                    src_pkt_done_out,
  output logic                    src_active_out,
  ptpp_if.src                     link_if
);
  import ptpp_pkg::*;

  // Both clock phases last HALF_CYC system cycles at least
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);  // RQ16

  ptpp_state_t state_r;
  ptpp_state_t state_nxt;
  ptpp_fmt_t   fmt_r;
  ptpp_fmt_t   fmt_cur;
  logic [7:0]  cnt_r;
  logic [7:0]  idx_r;
  logic [7:0]  last_idx;
  logic [7:0]  hold_r;
  logic        hold_full_r;
  logic        take;
  logic        slot_dummy;
  logic        byte_avail;
  logic        load_slot;
  logic        load;
  logic        lclk_r;
  logic [7:0]  data_r;
  logic        start_r;
  logic        bval_r;

  // Format is chosen at a packet boundary and held for the whole packet
  always_comb
  begin
    fmt_cur = fmt_r;
    if (idx_r == IDX_RESET)
    begin
      unique case (src_format_in)
        FMT_188:       fmt_cur = FMT_188;
        FMT_204_DUMMY: fmt_cur = FMT_204_DUMMY;
        FMT_204_RS:    fmt_cur = FMT_204_RS;
        default:       fmt_cur = FMT_188;  // Illegal code falls back to plain
      endcase
    end
  end

  // Packet length per format
  assign last_idx = (fmt_cur == FMT_188) ? LAST_188 : LAST_204;  // RQ1

  // Filler bytes are made here; the user only supplies 188 of them
  assign slot_dummy = (fmt_r == FMT_204_DUMMY) && (idx_r >= LEN_188)
                      && (idx_r != IDX_RESET);  // RQ2 RQ9
  assign byte_avail = slot_dummy || hold_full_r;

  // A new byte may go out only while the clock is low
  assign load_slot = (state_r == ST_IDLE)
                     || ((state_r == ST_HIGH) && (cnt_r == HALF_LAST));  // RQ5
  assign load      = load_slot && byte_avail;  // RQ11
  assign take      = src_valid_in && src_ready_out;

  // One-byte holding register toward the user
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      hold_r        <= DATA_RESET;
      hold_full_r   <= 1'b0;
      src_ready_out <= 1'b0;
    end
    else
    begin
      // Take and consume never coincide: take needs it empty
      if (take)
      begin
        hold_r        <= src_data_in;
        hold_full_r   <= 1'b1;
        src_ready_out <= 1'b0;
      end
      else if (load && !slot_dummy)
      begin
        hold_full_r   <= 1'b0;
        src_ready_out <= 1'b1;
      end
      else
      begin
        src_ready_out <= !hold_full_r;
      end
    end
  end

  // Byte position within the packet and the format in force
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      idx_r            <= IDX_RESET;
      fmt_r            <= FMT_188;
      src_pkt_done_out <= 1'b0;
    end
    else
    begin
      src_pkt_done_out <= load && (idx_r == last_idx);
      if (load)
      begin
        fmt_r <= fmt_cur;  // RQ2 RQ3
        if (idx_r == last_idx)
          idx_r <= IDX_RESET;  // RQ1
        else
          idx_r <= idx_r + 8'h01;
      end
    end
  end

  // Link lines, loaded together on the falling clock edge, or while the clock idles low
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      data_r  <= DATA_RESET;
      start_r <= 1'b0;
      bval_r  <= 1'b0;
    end
    else if (load)
    begin
      // Parity bytes pass through untouched; no coder is needed here
      data_r  <= slot_dummy ? DUMMY_BYTE : hold_r;  // RQ4 RQ6 RQ12
      start_r <= (idx_r == IDX_RESET);  // RQ10 RQ13
      bval_r  <= !slot_dummy;  // RQ7 RQ8 RQ9
    end
  end

  // Clock generator next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (load)
          state_nxt = ST_LOW;
      end
      ST_LOW:
      begin
        if (cnt_r == HALF_LAST)
          state_nxt = ST_HIGH;
      end
      ST_HIGH:
      begin
        if (cnt_r == HALF_LAST)
          state_nxt = load ? ST_LOW : ST_IDLE;  // RQ11
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Phase counter and clock level; one rising edge per byte
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r        <= ST_IDLE;
      cnt_r          <= CNT_RESET;
      lclk_r         <= 1'b0;
      src_active_out <= 1'b0;
    end
    else
    begin
      state_r        <= state_nxt;
      src_active_out <= (state_nxt != ST_IDLE);
      if (state_nxt != state_r)
        cnt_r <= CNT_RESET;
      else if (state_r != ST_IDLE)
        cnt_r <= cnt_r + 8'h01;
      // Rising edge sits mid-byte, so data has set up and holds
      lclk_r <= (state_nxt == ST_HIGH);  // RQ14 RQ15
    end
  end

  // Every link line comes straight from a flop
  assign link_if.lclk              = lclk_r;
  assign link_if.data              = data_r;
  assign link_if.packet_start_flag = start_r;
  assign link_if.byte_valid_flag   = bval_r;
endmodule

`default_nettype wire

// ===== design/ptpp_sync2.sv
// Two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
`default_nettype none

module ptpp_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

`default_nettype wire

// ===== testbench/ptpp_assertions.sv
// Checker on the link wires between the packet source and the sink
`timescale 1ns/1ps
`default_nettype none

module ptpp_assertions (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       lclk,
  input  wire logic [7:0] data,
  input  wire logic       packet_start_flag,
  input  wire logic       byte_valid_flag
);
  import ptpp_pkg::*;

  logic       lclk_r;
  logic [7:0] cnt_r;
  logic       rise;

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // Link rise seen from the system domain
  assign rise = lclk & ~lclk_r;

  // Bytes seen since the last start; reset clears a half packet
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      lclk_r <= 1'b0;
      cnt_r  <= CNT_RESET;
    end
    else
    begin
      lclk_r <= lclk;
      if (rise)
        cnt_r <= packet_start_flag ? 8'h01 : cnt_r + 8'h01;
    end
  end

  property p_len;
    rise && packet_start_flag && cnt_r != 8'h00 |-> cnt_r == LEN_188 || cnt_r == LEN_204;
  endproperty
  a_len: assert property (p_len) else $error("packet length wrong");

  property p_max;
    rise && !packet_start_flag |-> cnt_r <= LAST_204;
  endproperty
  a_max: assert property (p_max) else $error("packet too long");

  property p_fill;
    rise && !byte_valid_flag |-> !packet_start_flag && cnt_r >= LEN_188;
  endproperty
  a_fill: assert property (p_fill) else $error("valid low outside filler");

  property p_fill_data;
    rise && !byte_valid_flag |-> data == DUMMY_BYTE;
  endproperty
  a_fill_data: assert property (p_fill_data) else $error("filler content wrong");

  property p_hold;
    lclk && lclk_r |-> $stable({data, packet_start_flag, byte_valid_flag});
  endproperty
  a_hold: assert property (p_hold) else $error("lines moved while clock high");

  property p_chg;
    !$stable(data) |-> !lclk;
  endproperty
  a_chg: assert property (p_chg) else $error("data changed off the falling edge");

  property p_hi;
    $rose(lclk) |=> lclk [*3] ##1 !lclk;
  endproperty
  a_hi: assert property (p_hi) else $error("clock high width wrong");

  property p_lo;
    $fell(lclk) |-> !lclk [*4];
  endproperty
  a_lo: assert property (p_lo) else $error("clock low too short");

  property p_start;
    $rose(packet_start_flag) |-> !lclk ##1 packet_start_flag [*7];
  endproperty
  a_start: assert property (p_start) else $error("start flag too short");

  // Main traffic shapes
  c_204: cover property (rise && packet_start_flag && cnt_r == LEN_204);
  c_188: cover property (rise && packet_start_flag && cnt_r == LEN_188);
  c_fill: cover property (rise && !byte_valid_flag);
endmodule

`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench: source and sink joined over the link wires
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ptpp_pkg::*;

  typedef struct packed
  {
    logic       fc;
    logic       rs;
    logic       st;
    logic       bv;
    logic [7:0] d;
    ptpp_fmt_t  pf;
  } ptpp_exp_t;

  logic       clk_in;
  logic       sys_rst_in;
  logic       src_valid_in;
  logic       src_ready_out;
  logic       snk_strobe_out;
  logic       snk_start_out;
  logic       snk_byte_valid_out;
  logic       snk_rs_check_out;
  logic       snk_len_err_out;
  logic       bad_err;
  logic       bad_seen;
  logic       src_pkt_done_out;
  logic       src_active_out;
  logic [7:0] src_data_in;
  logic [7:0] snk_data_out;
  ptpp_fmt_t  src_format_in;
  ptpp_fmt_t  snk_format_out;
  ptpp_fmt_t  prev_fmt;
  ptpp_fmt_t  fmts [4];
  ptpp_exp_t  exp_q [$];
  ptpp_exp_t  e;
  int         n_errors;
  int         num_checks;
  int         n_pkts = 0;
  int         n_done = 0;

  ptpp_if ptpp_if_i ();
  ptpp_if bad_if ();

  ptpp_src ptpp_src_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .src_data_in(src_data_in),
    .src_valid_in(src_valid_in), .src_ready_out(src_ready_out),
    .src_format_in(src_format_in), .src_pkt_done_out(src_pkt_done_out),
    .src_active_out(src_active_out), .link_if(ptpp_if_i));

  ptpp_snk ptpp_snk_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_if(ptpp_if_i),
    .snk_data_out(snk_data_out), .snk_strobe_out(snk_strobe_out),
    .snk_start_out(snk_start_out), .snk_byte_valid_out(snk_byte_valid_out),
    .snk_rs_check_out(snk_rs_check_out), .snk_format_out(snk_format_out),
    .snk_len_err_out(snk_len_err_out));

  // Second sink fed by a bench driver that breaks the packet length
  ptpp_snk ptpp_snk_i2 (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_if(bad_if),
    .snk_data_out(), .snk_strobe_out(), .snk_start_out(),
    .snk_byte_valid_out(), .snk_rs_check_out(), .snk_format_out(),
    .snk_len_err_out(bad_err));

  ptpp_assertions ptpp_assertions_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .lclk(ptpp_if_i.lclk),
    .data(ptpp_if_i.data), .packet_start_flag(ptpp_if_i.packet_start_flag),
    .byte_valid_flag(ptpp_if_i.byte_valid_flag));

  // System clock
  always #5 clk_in = ~clk_in;

  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Expected sink view of byte i of a packet in format g; filler only in dummy mode
  function automatic ptpp_exp_t exp_byte(input ptpp_fmt_t g, input int i,
                                         input logic [7:0] b, input ptpp_fmt_t pf);
    ptpp_exp_t x;
    logic      fill;
    fill = (g == FMT_204_DUMMY) && (i >= 188);
    x.fc = (i == 1);
    x.rs = (g == FMT_204_RS) && (i >= 188);
    x.st = (i == 0);
    x.bv = !fill;
    x.d  = fill ? DUMMY_BYTE : b;
    x.pf = pf;
    return x;
  endfunction

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Offer one byte; returns at the edge that takes it
  task automatic offer(input logic [7:0] b);
    int k;
    src_data_in  <= b;
    src_valid_in <= 1'b1;
    k = 0;
    @(negedge clk_in);
    while (src_ready_out !== 1'b1)
    begin
      k++;
      // Sixteen filler slots of eight cycles each can sit ahead of a byte
      if (k > 400)
      begin
        check(12'h001, 12'h000);
        end_of_test();
      end
      @(negedge clk_in);
    end
    @(posedge clk_in);
  endtask

  // One packet; an unknown code must travel as plain 188
  task automatic send_pkt(input ptpp_fmt_t f, input int gap);
    ptpp_fmt_t  g;
    int         n;
    int         m;
    logic [7:0] b;
    g = (f == FMT_204_DUMMY || f == FMT_204_RS) ? f : FMT_188;
    n = (g == FMT_204_RS) ? 204 : 188;
    m = (g == FMT_188) ? 188 : 204;
    src_format_in <= f;
    for (int i = 0; i < m; i++)
    begin
      b = (i == 0) ? 8'h47 : 8'($urandom);
      exp_q.push_back(exp_byte(g, i, b, prev_fmt));
      if (i < n)
        offer(b);
      if (i < n && gap > 0 && $urandom_range(3) == 0)
      begin
        src_valid_in <= 1'b0;
        repeat (gap) @(posedge clk_in);
      end
    end
    n_pkts++;
    prev_fmt = g;
  endtask

  // Valid stays up between packets; it drops here so the last byte is not taken twice
  task automatic drain();
    src_valid_in <= 1'b0;
    for (int k = 0; k < 3000 && exp_q.size() != 0; k++)
      @(negedge clk_in);
    if (exp_q.size() != 0)
    begin
      check(12'h002, 12'h000);
      end_of_test();
    end
    check(12'(n_done), 12'(n_pkts));
  endtask

  // Broken link: 6 ns clock pulses, idling low between bytes so the sink keeps up
  task automatic bad_byte(input logic st);
    bad_if.data = 8'($urandom);
    bad_if.packet_start_flag = st;
    #90 bad_if.lclk = 1'b1;
    #6 bad_if.lclk = 1'b0;
  endtask

  // Sink outputs against the expected stream, sampled off the edge
  always @(negedge clk_in)
  begin
    if (sys_rst_in === 1'b0)
    begin
      check({11'h000, snk_len_err_out}, 12'h000);
      if (src_pkt_done_out === 1'b1)
        n_done++;
      // An idle source keeps its byte clock parked low
      if (src_active_out !== 1'b1)
        check({11'h000, ptpp_if_i.lclk}, 12'h000);
      if (snk_strobe_out === 1'b1 && exp_q.size() == 0)
        check(12'h003, 12'h000);
      else if (snk_strobe_out === 1'b1)
      begin
        e = exp_q.pop_front();
        check({1'b0, snk_rs_check_out, snk_start_out, snk_byte_valid_out, snk_data_out},
              {1'b0, e.rs, e.st, e.bv, e.d});
        if (e.fc)
          check({9'h000, snk_format_out}, {9'h000, e.pf});
      end
    end
  end

  // Main sequence
  initial
  begin
    clk_in = 1'b0;
    sys_rst_in = 1'b1;
    src_valid_in = 1'b0;
    src_data_in = 8'h00;
    src_format_in = FMT_188;
    prev_fmt = FMT_188;
    fmts = '{FMT_188, FMT_204_DUMMY, FMT_204_RS, ptpp_fmt_t'(3'b011)};
    bad_if.lclk = 1'b0;
    bad_if.data = 8'h00;
    bad_if.packet_start_flag = 1'b0;
    bad_if.byte_valid_flag = 1'b1;
    n_errors = 0;
    num_checks = 0;
    void'($urandom(32'hBF6A3DE9));
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    // Every format back to back, then random formats with underruns
    for (int i = 0; i < 4; i++)
      send_pkt(fmts[i], 0);
    for (int i = 0; i < 6; i++)
      send_pkt(fmts[$urandom_range(3)], 1 + $urandom_range(20));
    drain();
    // Second reset: everything back to rest, then a fresh stream
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    @(negedge clk_in);
    check({6'h00, src_active_out, src_pkt_done_out, src_ready_out, snk_strobe_out,
           snk_len_err_out, ptpp_if_i.lclk}, 12'h000);
    check({9'h000, snk_format_out}, {9'h000, FMT_188});
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    exp_q.delete();
    prev_fmt = FMT_188;
    @(posedge clk_in);
    send_pkt(FMT_204_RS, 0);
    send_pkt(FMT_204_DUMMY, 3);
    send_pkt(FMT_188, 0);
    drain();
    // A six-byte packet on the second link must be flagged
    bad_byte(1'b1);
    repeat (5) bad_byte(1'b0);
    bad_byte(1'b1);
    bad_seen = 1'b0;
    for (int k = 0; k < 30; k++)
    begin
      @(negedge clk_in);
      if (bad_err === 1'b1)
        bad_seen = 1'b1;
    end
    check({11'h000, bad_seen}, 12'h001);
    end_of_test();
  end
endmodule

`default_nettype wire
